// >>> hw/asc_top.sv
// Purpose: serial control byte intake and SAR sequencing for a 4-input ADC
// Assumes: serial clock far slower than ref_clk_in (8 samples per period)
// Notes: all asynchronous pins synchronised; outputs registered; results queued in FIFO
`timescale 1ns/1ps
`default_nettype none
module asc_top import asc_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic cs_n_in, // chip select, active low
  input wire logic sclk_in, // serial clock from host
  input wire logic din_in, // serial data in
  input wire logic hw_shutdown_n_in, // hardware shutdown, active low
  input wire logic comparator_in, // SAR comparator: input above DAC
  input wire logic result_ready_in, // result port consumer ready
  output logic dout_out, // serial data out
  output logic dout_oe_out, // high while dout is driven
  output logic conversion_strobe_out,
  output logic strobe_oe_out, // high while strobe is driven
  output logic track_out, // sampling switch closed
  output logic hold_out, // sample held, converting
  output logic [1:0] pos_chan_out, // positive input channel
  output logic [1:0] neg_chan_out, // negative input channel
  output logic neg_common_out, // negative input on common return
  output logic bipolar_out, // bipolar offset applied
  output logic [RES_BITS-1:0] dac_code_out, // SAR trial code
  output logic [1:0] power_mode_out, // applied power mode
  output logic shutdown_out, // hardware shutdown in force
  output logic por_busy_out, // reset interval running
  output logic result_valid_out,
  output logic [RES_BITS-1:0] result_data_out,
  output logic result_space_out // FIFO can take another result
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1_q; // first stage, read only by second
  logic [4:0] pin_s2_q; // second stage
  logic sclk_d_q; // previous synced clock for edge find
  logic cs_low; // chip selected
  logic din_s;
  logic hw_shutdown_n_s; // shutdown asserted
  logic comp_s;
  logic rise_ev; // serial clock rising edge seen
  logic fall_ev; // serial clock falling edge seen
  // two flops on every asynchronous pin
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_q <= 5'h09; // idle levels: deselected, shutdown released
      pin_s2_q <= 5'h09; // so no false shutdown follows reset
      sclk_d_q <= 1'b0;
    end else begin
      pin_s1_q <= {comparator_in, hw_shutdown_n_in, din_in, sclk_in, cs_n_in};
      pin_s2_q <= pin_s1_q;
      sclk_d_q <= pin_s2_q[1];
    end
  end
  assign cs_low = !pin_s2_q[0];
  assign din_s = pin_s2_q[2];
  assign hw_shutdown_n_s = !pin_s2_q[3];
  assign comp_s = pin_s2_q[4];
  assign rise_ev = pin_s2_q[1] && !sclk_d_q;
  assign fall_ev = !pin_s2_q[1] && sclk_d_q;
  // ----------------------------------------------------------------
  // power-on reset interval
  // ----------------------------------------------------------------
  logic [$clog2(POR_CYCLES+1)-1:0] por_q; // counts down to zero
  logic por_busy;
  // host must not convert yet; starts are ignored meanwhile
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      por_q <= ($clog2(POR_CYCLES+1))'(POR_CYCLES);
    end else if (por_q != '0) begin
      por_q <= por_q - 1'b1;
    end
  end
  assign por_busy = (por_q != '0);
  // ----------------------------------------------------------------
  // control byte intake
  // ----------------------------------------------------------------
  asc_in_st_t in_q; // intake state
  logic [CTRL_BITS-1:0] shreg_q; // incoming control byte
  logic [3:0] nbits_q; // bits taken so far
  asc_cv_st_t cv_q; // conversion state
  logic [3:0] fcnt_q; // falling edges since hold
  logic start_ok;
  logic launch; // hold edge: conversion begins
  // a start is taken when idle or once bit four is out
  assign start_ok = (cv_q == CV_IDLE) || (fcnt_q >= FR_OVERLAP);
  assign launch = fall_ev && (in_q == IN_WAIT) && !hw_shutdown_n_s;
  // shift register on rising edges while selected
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_q <= IN_HUNT;
      shreg_q <= '0;
      nbits_q <= '0;
    end else if (hw_shutdown_n_s) begin
      in_q <= IN_HUNT;
      nbits_q <= '0;
    end else begin
      case (in_q)
        IN_HUNT: begin
          // leading zeros fall through; first one opens the byte
          if (rise_ev && cs_low && din_s && start_ok && !por_busy) begin
            shreg_q <= {{(CTRL_BITS-1){1'b0}}, 1'b1};
            nbits_q <= 4'h1;
            in_q <= IN_BITS;
          end
        end
        IN_BITS: begin
          if (rise_ev && cs_low) begin
            shreg_q <= {shreg_q[CTRL_BITS-2:0], din_s};
            nbits_q <= nbits_q + 4'h1;
            if (nbits_q == 4'(CTRL_BITS-1)) begin
              in_q <= IN_WAIT;
            end
          end
        end
        IN_WAIT: begin
          if (fall_ev) begin
            in_q <= IN_HUNT;
          end
        end
        default: in_q <= IN_HUNT;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  logic [RES_BITS-1:0] sar_q; // trial and decided bits
  logic bip_q; // bipolar coding of this conversion
  logic [1:0] pm_pend_q; // mode to apply at the end
  logic [3:0] fnext; // falling edge index being served
  logic [3:0] bidx; // result bit decided at this edge
  logic decide; // this edge carries a decision
  assign fnext = fcnt_q + 4'h1;
  assign bidx = FR_LSB - fnext;
  assign decide = (fnext >= FR_MSB) && (fnext <= FR_LSB);
  // only shutdown clears a running conversion
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cv_q <= CV_IDLE;
      fcnt_q <= '0;
    end else if (hw_shutdown_n_s) begin
      cv_q <= CV_IDLE;
      fcnt_q <= '0;
    end else if (launch) begin
      cv_q <= CV_RUN;
      fcnt_q <= '0;
    end else if (fall_ev && cv_q == CV_RUN) begin
      fcnt_q <= fnext;
      if (fnext == FR_END) begin
        cv_q <= CV_IDLE;
      end
    end
  end
  // SAR register: MSB trial at hold, one decision per falling edge three to twelve
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sar_q <= '0;
    end else if (launch) begin
      sar_q <= {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (fall_ev && cv_q == CV_RUN && decide) begin
      sar_q[bidx] <= comp_s;
      if (bidx != 4'h0) begin
        sar_q[bidx-4'h1] <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // analog front-end controls
  // ----------------------------------------------------------------
  logic [2:0] sel; // {hi, mid, lo} of the byte being taken
  assign sel = shreg_q[CB_SEL_HI:CB_SEL_LO];
  // track from bit five, hold from bit eight until the frame ends
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      track_out <= 1'b0;
      hold_out <= 1'b0;
    end else if (hw_shutdown_n_s) begin
      track_out <= 1'b0;
      hold_out <= 1'b0;
    end else if (fall_ev && in_q == IN_BITS && nbits_q == 4'(TRACK_BIT)) begin
      track_out <= 1'b1;
    end else if (launch) begin
      track_out <= 1'b0;
      hold_out <= 1'b1;
    end else if (fall_ev && cv_q == CV_RUN && fnext == FR_END) begin
      hold_out <= 1'b0;
    end
  end
  // mux and mode captured at the same edge the sample is held;
  // unlisted select codes steer somewhere, but nothing relies on it
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos_chan_out <= 2'h0;
      neg_chan_out <= 2'h0;
      neg_common_out <= 1'b1;
      bipolar_out <= 1'b0;
      bip_q <= 1'b0;
      pm_pend_q <= PM_NORMAL;
    end else if (launch) begin
      pos_chan_out <= asc_pos_chan(sel);
      neg_chan_out <= asc_pos_chan(sel) ^ 2'h1;
      neg_common_out <= shreg_q[CB_CFG];
      bipolar_out <= !shreg_q[CB_POL];
      bip_q <= !shreg_q[CB_POL];
      pm_pend_q <= shreg_q[CB_PM_HI:CB_PM_LO];
    end
  end
  // full power while converting, chosen mode once it is done
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      power_mode_out <= PM_NORMAL;
      shutdown_out <= 1'b0;
    end else begin
      shutdown_out <= hw_shutdown_n_s;
      if (launch) begin
        power_mode_out <= PM_NORMAL;
      end else if (fall_ev && cv_q == CV_RUN && fnext == FR_END) begin
        power_mode_out <= pm_pend_q;
      end
    end
  end
  // ----------------------------------------------------------------
  // serial outputs
  // ----------------------------------------------------------------
  logic dec_bit; // coded decision for this edge
  // bipolar flips the MSB: offset binary becomes two's complement
  assign dec_bit = (bidx == 4'(RES_BITS-1)) ? (comp_s ^ bip_q) : comp_s;
  // dout changes on falling edges; zeros outside the ten result bits
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dout_out <= 1'b0;
    end else if (hw_shutdown_n_s || launch) begin
      dout_out <= 1'b0;
    end else if (fall_ev && cv_q == CV_RUN) begin
      dout_out <= decide ? dec_bit : 1'b0;
    end
  end
  // strobe: hold edge to the next falling edge; low when deselected
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      conversion_strobe_out <= 1'b0;
    end else if (!cs_low || hw_shutdown_n_s) begin
      conversion_strobe_out <= 1'b0;
    end else if (launch) begin
      conversion_strobe_out <= 1'b1;
    end else if (fall_ev) begin
      conversion_strobe_out <= 1'b0;
    end
  end
  // drivers enabled only while selected
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dout_oe_out <= 1'b0;
      strobe_oe_out <= 1'b0;
    end else begin
      dout_oe_out <= cs_low;
      strobe_oe_out <= cs_low;
    end
  end
  // ----------------------------------------------------------------
  // result queue
  // ----------------------------------------------------------------
  asc_fifo_if #(.W(RES_BITS)) rq ();
  logic push_q; // one-cycle push at the end of the frame
  logic [RES_BITS-1:0] word_q;
  // a result that finds the queue full is lost, not stalled: the
  // conversion cannot wait, so room is reported on result_space_out
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      push_q <= 1'b0;
      word_q <= '0;
    end else begin
      push_q <= fall_ev && cv_q == CV_RUN && fnext == FR_END && !hw_shutdown_n_s;
      word_q <= {sar_q[RES_BITS-1] ^ bip_q, sar_q[RES_BITS-2:0]};
    end
  end
  assign rq.push_valid = push_q;
  assign rq.push_data = word_q;
  assign rq.pop_ready = result_ready_in && result_valid_out;
  asc_fifo #(.W(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .port(rq)
  );
  // registered copies of the queue head and room
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_valid_out <= 1'b0;
      result_data_out <= '0;
      result_space_out <= 1'b0;
      dac_code_out <= '0;
      por_busy_out <= 1'b1;
    end else begin
      result_valid_out <= rq.pop_valid && !rq.pop_ready;
      result_data_out <= rq.pop_data;
      result_space_out <= rq.push_ready;
      dac_code_out <= sar_q;
      por_busy_out <= por_busy;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_strobe_at_hold: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    launch && cs_low |=> conversion_strobe_out) else $error("strobe missed hold edge");
  a_strobe_one_clk: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    conversion_strobe_out && fall_ev |=> !conversion_strobe_out)
    else $error("strobe longer than one clock");
  a_float_deselect: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !cs_low |=> !dout_oe_out && !strobe_oe_out) else $error("driving while deselected");
  a_track_bit_five: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fall_ev && in_q == IN_BITS && nbits_q == 4'h5 && !hw_shutdown_n_s |=> track_out)
    else $error("track not started");
  a_hold_starts_conv: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(hold_out) |-> cv_q == CV_RUN && fcnt_q == 4'h0) else $error("hold without start");
  a_shutdown_stops: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    hw_shutdown_n_s |=> cv_q == CV_IDLE && !hold_out) else $error("shutdown ignored");
  a_full_power_conv: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cv_q == CV_RUN |-> power_mode_out == PM_NORMAL) else $error("low power while converting");
  a_lead_zeros: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cv_q == CV_RUN && fcnt_q < FR_MSB |-> !dout_out) else $error("leading zero violated");
  a_chan_pairing: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(hold_out) |-> neg_chan_out == (pos_chan_out ^ 2'h1)) else $error("bad pairing");
endmodule // asc_top
`default_nettype wire

// >>> hw/asc_pkg.sv
// Purpose: constants and types for the serial ADC conversion controller
// Assumes: 10 MHz core clock, serial clock sampled as a plain input
// Notes: shared by the controller and its result FIFO
package asc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int POR_TIME_NS = 10_000;
  localparam int POR_CYCLES = (POR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // ----------------------------------------------------------------
  // control byte layout
  // ----------------------------------------------------------------
  localparam int CTRL_BITS = 8;
  localparam int TRACK_BIT = 5;
  localparam int CB_SEL_HI = 6;
  localparam int CB_SEL_LO = 4;
  localparam int CB_POL = 3;
  localparam int CB_CFG = 2;
  localparam int CB_PM_HI = 1;
  localparam int CB_PM_LO = 0;
  // ----------------------------------------------------------------
  // result frame, in falling edges counted from the hold edge
  // ----------------------------------------------------------------
  localparam int RES_BITS = 10;
  localparam logic [3:0] FR_MSB = 4'h3;
  localparam logic [3:0] FR_LSB = 4'hC;
  localparam logic [3:0] FR_OVERLAP = 4'h8;
  localparam logic [3:0] FR_END = 4'hF;
  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  localparam logic [1:0] PM_FULL_PD = 2'h0;
  localparam logic [1:0] PM_FAST_PD = 2'h1;
  localparam logic [1:0] PM_REDUCED = 2'h2;
  localparam logic [1:0] PM_NORMAL = 2'h3;
  typedef enum logic [1:0] {IN_HUNT, IN_BITS, IN_WAIT} asc_in_st_t;
  typedef enum logic {CV_IDLE, CV_RUN} asc_cv_st_t;
  // positive channel from {hi,mid,lo}; negative of a pair is its twin
  function automatic logic [1:0] asc_pos_chan(input logic [2:0] sel);
    asc_pos_chan = {sel[1], sel[2]};
  endfunction
endpackage

// >>> hw/asc_fifo_if.sv
// Purpose: carries result words from the controller into its FIFO
// Assumes: one clock domain, valid/ready handshake on both sides
// Notes: width follows the result word
`timescale 1ns/1ps
`default_nettype none
interface asc_fifo_if #(parameter int W = 10);
  logic push_valid; // producer offers a word
  logic push_ready; // FIFO has room
  logic [W-1:0] push_data;
  logic pop_valid; // FIFO holds a word
  logic pop_ready; // consumer takes it
  logic [W-1:0] pop_data;
  modport wr(output push_valid, output push_data, input push_ready,
             input pop_valid, input pop_data, output pop_ready);
  modport fifo(input push_valid, input push_data, output push_ready,
               output pop_valid, output pop_data, input pop_ready);
endinterface
`default_nettype wire

// >>> hw/asc_fifo.sv
// Purpose: small result FIFO between conversions and the result port
// Assumes: depth a power of two, at least two
// Notes: full and empty come from an explicit occupancy count
`timescale 1ns/1ps
`default_nettype none
module asc_fifo import asc_pkg::*; #(
  parameter int W = RES_BITS,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  asc_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [W-1:0] mem_q [DEPTH]; // word store
  logic [AW-1:0] wr_q; // write slot
  logic [AW-1:0] rd_q; // read slot
  logic [AW:0] cnt_q; // occupancy
  logic do_push;
  logic do_pop;
  // refuse depths the pointer wrap cannot serve, at elaboration
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("asc_fifo depth must be a power of two");
  end
  assign do_push = port.push_valid && port.push_ready;
  assign do_pop = port.pop_valid && port.pop_ready;
  assign port.push_ready = (cnt_q != (AW+1)'(DEPTH));
  assign port.pop_valid = (cnt_q != '0);
  assign port.pop_data = mem_q[rd_q];
  // data store, no reset needed
  always_ff @(posedge ref_clk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= port.push_data;
    end
  end
  // pointers and count
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // asc_fifo
`default_nettype wire

// >>> tb/asc_host.sv
// Purpose: serial master model standing in for the host controller
// Assumes: mode zero framing, sclk period of 8 ref clocks (800 ns)
// Notes: sclk stands low outside frames; a released dout reads inverted
`timescale 1ns/1ps
`default_nettype none
module asc_host (
  input wire logic ref_clk_in,
  input wire logic dout_in,
  input wire logic dout_oe_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out
);
  // ----------------------------------------
  // line level seen by the host
  // ----------------------------------------
  logic last_q; // last driven dout, so a floating line never looks valid
  wire logic line_w = dout_oe_in ? dout_in : ~last_q;
  always @(posedge ref_clk_in) begin
    if (dout_oe_in) last_q <= dout_in;
  end
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0; // idle low, clock polarity zero
    din_out = 1'b0;
    last_q = 1'b0;
  end
  // ----------------------------------------
  // one frame: n bits out msb first, rx collected at each rising sclk
  // ----------------------------------------
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    cs_n_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    for (int i = n - 1; i >= 0; i--) begin
      din_out <= tx[i]; // data set while sclk low, phase zero
      repeat (4) @(posedge ref_clk_in);
      rx = {rx[30:0], line_w};
      sclk_out <= 1'b1; // 1.25 MHz, inside the allowed range
      repeat (4) @(posedge ref_clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_in);
    cs_n_out <= 1'b1; // frame of 27 bits well under 120 us
    din_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
endmodule // asc_host
`default_nettype wire

// >>> tb/asc_top_tb.sv
// Purpose: self-checking bench for the serial conversion controller
// Assumes: host model drives the link; comparator models a fixed level
// Notes: comparator uses >= so the sar settles exactly on the level
`timescale 1ns/1ps
`default_nettype none
module asc_top_tb import asc_pkg::*;;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk = 1'b0, nrst = 1'b0, sd_n = 1'b1, comp = 1'b0, rdy = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, strb, strb_oe, track, hold, neg_com, bip;
  logic shut, por_busy, res_valid, res_space;
  logic [1:0] pos_ch, neg_ch, pm;
  logic [9:0] dac, res_data, analog = 10'h000;
  int fails = 0, checked = 0, strb_cnt, trk_cnt, hld_cnt;
  logic [9:0] q[$]; // expected results in fifo order
  always #50 ref_clk = ~ref_clk; // 10 MHz
  asc_host i_asc_host (.ref_clk_in(ref_clk), .dout_in(dout), .dout_oe_in(dout_oe),
    .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
  asc_top #(.FIFO_DEPTH(4)) i_asc_top (.ref_clk_in(ref_clk), .nrst_in(nrst),
    .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .hw_shutdown_n_in(sd_n),
    .comparator_in(comp), .result_ready_in(rdy), .dout_out(dout), .dout_oe_out(dout_oe),
    .conversion_strobe_out(strb), .strobe_oe_out(strb_oe), .track_out(track),
    .hold_out(hold), .pos_chan_out(pos_ch), .neg_chan_out(neg_ch),
    .neg_common_out(neg_com), .bipolar_out(bip), .dac_code_out(dac),
    .power_mode_out(pm), .shutdown_out(shut), .por_busy_out(por_busy),
    .result_valid_out(res_valid), .result_data_out(res_data),
    .result_space_out(res_space));
  // comparator model and pulse-width counters
  always @(posedge ref_clk) begin
    comp <= (analog >= dac);
    if (strb === 1'b1) strb_cnt++;
    if (track === 1'b1) trk_cnt++;
    if (hold === 1'b1) hld_cnt++;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  function automatic logic [1:0] exp_pos(input logic [2:0] s);
    case (s)
      3'b001: return 2'h0;
      3'b101: return 2'h1;
      3'b010: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction
  // one conversion, three leading zeros before the start bit
  task automatic t_conv(input logic [7:0] ctrl, input logic [9:0] a);
    logic [31:0] rx;
    logic [9:0] e;
    analog = a;
    strb_cnt = 0;
    trk_cnt = 0;
    hld_cnt = 0;
    e = ctrl[3] ? a : {~a[9], a[8:0]};
    i_asc_host.xfer({8'h00, ctrl, 16'h0000}, 27, rx);
    @(negedge ref_clk);
    `CHK(rx[15:0], {3'h0, e, 3'h0})
    `CHK(strb_cnt, 8)
    `CHK(trk_cnt, 24)
    `CHK(hld_cnt, 120)
    `CHK(dac, a)
    `CHK({dout_oe, strb_oe}, 2'h0)
    `CHK(pm, ctrl[1:0])
    `CHK({neg_com, bip}, {ctrl[2], ~ctrl[3]})
    `CHK(pos_ch, exp_pos(ctrl[6:4]))
    if (!ctrl[2]) `CHK(neg_ch, exp_pos(ctrl[6:4]) ^ 2'h1)
    q.push_back(e);
  endtask
  // back-to-back conversions, second start bit right after B4 is out
  task automatic t_overlap(input logic [9:0] a);
    logic [31:0] rx;
    logic [31:0] rx2;
    analog = a;
    i_asc_host.xfer({8'h9D, 8'h00, 8'hAF, 8'h00}, 32, rx);
    i_asc_host.xfer(32'h0000_0000, 16, rx2);
    @(negedge ref_clk);
    `CHK(rx[23:8], {3'h0, a, 3'h0})
    `CHK({rx[4:0], rx2[15:11]}, a)
    q.push_back(a);
    q.push_back(a);
  endtask
  // drain the fifo in order, one pop at a time
  task automatic t_drain();
    int n;
    while (q.size() > 0) begin
      n = 0;
      while (res_valid !== 1'b1 && n < 20) begin
        @(negedge ref_clk);
        n++;
      end
      `CHK(res_data, q.pop_front())
      @(posedge ref_clk) rdy <= 1'b1;
      @(posedge ref_clk) rdy <= 1'b0;
      @(negedge ref_clk);
    end
  endtask
  // shutdown in mid-conversion stops it and drops its result
  task automatic t_shut();
    logic [31:0] rx;
    fork
      i_asc_host.xfer({8'h00, 8'hDF, 16'h0000}, 27, rx);
      begin
        repeat (130) @(posedge ref_clk);
        sd_n <= 1'b0;
      end
    join
    @(negedge ref_clk);
    `CHK({shut, hold, track, strb}, 4'h8)
    @(posedge ref_clk) sd_n <= 1'b1;
    repeat (10) @(negedge ref_clk);
    `CHK(res_valid, 1'b0)
  endtask
  task automatic give_verdict();
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    logic [2:0] sel_tab[4] = '{3'b001, 3'b101, 3'b010, 3'b110};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    `CHK({pm, por_busy, strb}, 4'hE)
    repeat (POR_CYCLES + 8) @(posedge ref_clk); // host waits out reset
    @(negedge ref_clk);
    `CHK({por_busy, dout_oe}, 2'h0)
    for (int i = 0; i < 8; i++) begin
      t_conv({1'b1, sel_tab[i % 4], i[0], (i < 4), i[1:0]}, 10'h2AB + 10'(i * 37));
      if (i == 3) `CHK(res_space, 1'b0)
      if (i % 4 == 3) t_drain();
    end
    t_overlap(10'h1C6);
    t_drain();
    t_shut();
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
endmodule // asc_top_tb
`default_nettype wire
